//--- shared/dmc_pkg.sv
// Purpose : Shared constants and types for the module command/control pin logic
// Assumes : One reference clock, all pins synchronous to it
// Notes   : Every field position and encoding used by the design lives here, except the command bit and strap address packing in dmc_ctrl
package dmc_pkg;

   // ----------------------------------------------------------------
   // Organisation and widths
   // ----------------------------------------------------------------
   localparam int RANKS_DEF   = 2;
   localparam int ADDR_W      = 17;
   localparam int BG_W        = 2;
   localparam int BA_W        = 2;
   localparam int SA_W        = 3;
   localparam int DQ_X4       = 4;
   localparam int DQ_X8       = 8;
   localparam int DQ_X16      = 16;
   localparam int CB_W        = 8;
   localparam int ORG_W       = 2;
   localparam int VREF_LANES  = 4;

   // Organisation codes
   localparam logic [1:0] ORG_X4  = 2'h0;
   localparam logic [1:0] ORG_X8  = 2'h1;
   localparam logic [1:0] ORG_X16 = 2'h2;

   // Row address bit positions shared with command pins
   localparam int ROW_RAS_BIT = 16;
   localparam int ROW_CAS_BIT = 15;
   localparam int ROW_WE_BIT  = 14;

   // Termination vector positions: dq lanes, strobes, mask, tdqs_c
   localparam int TERM_W       = 22;
   localparam int TERM_DQS_LO  = 16;
   localparam int TERM_DQS_UP  = 17;
   localparam int TERM_DM_LO   = 18;
   localparam int TERM_DM_UP   = 19;
   localparam int TERM_TDQS_C  = 20;
   localparam int TERM_SPARE   = 21;

   // Input buffer enable vector positions
   localparam int BUF_W    = 5;
   localparam int BUF_CK   = 0;
   localparam int BUF_ODT  = 1;
   localparam int BUF_RST  = 2;
   localparam int BUF_CKE  = 3;
   localparam int BUF_CMD  = 4;

   // Base presence-detect and sensor bus addresses (arbitrary defaults)
   localparam logic [6:0] SPD_BASE  = 7'h50;
   localparam logic [6:0] TSEN_BASE = 7'h18;

   // Power states, Gray coded along the APD and SREF entry/exit paths
   typedef enum logic [1:0] {
      PWR_ACTIVE = 2'b00,
      PWR_APD    = 2'b01,
      PWR_PPD    = 2'b11,
      PWR_SREF   = 2'b10
   } dmc_pwr_type;

endpackage : dmc_pkg

//--- src/dmc_parity.sv
// Purpose : Command/address parity check
// Assumes : Inputs sampled on the reference clock edge
// Notes   : Flags a mismatch only on a selected command with parity on
`timescale 1ns/1ps
`default_nettype none
module dmc_parity (
   input  wire logic                      i_en,
   input  wire logic                      i_sel,
   input  wire logic                      i_act_n,
   input  wire logic                      i_ras_n,
   input  wire logic                      i_cas_n,
   input  wire logic                      i_we_n,
   input  wire logic [dmc_pkg::BG_W-1:0]  i_bg,
   input  wire logic [dmc_pkg::BA_W-1:0]  i_ba,
   input  wire logic [dmc_pkg::ADDR_W-1:0] i_addr,
   input  wire logic                      i_par,
   output logic                           o_err
);
   // ----------------------------------------------------------------
   // Even parity over the covered pins
   // ----------------------------------------------------------------
   logic calc;
   always_comb begin
      calc  = ^{i_act_n, i_ras_n, i_cas_n, i_we_n, i_bg, i_ba, i_addr};
      o_err = i_en & i_sel & (calc != i_par);
   end
endmodule : dmc_parity
`default_nettype wire

//--- src/dmc_term.sv
// Purpose : On-die termination pin map
// Assumes : Termination request already registered
// Notes   : Lanes above the organisation width stay unterminated
`timescale 1ns/1ps
`default_nettype none
module dmc_term (
   input  wire logic                        i_on,
   input  wire logic [dmc_pkg::ORG_W-1:0]   i_org,
   input  wire logic                        i_tdqs_en,
   output logic [dmc_pkg::TERM_W-1:0]       o_term
);
   // ----------------------------------------------------------------
   // Per-lane termination enables
   // ----------------------------------------------------------------
   logic x16;
   int   width;
   always_comb begin
      x16   = (i_org == dmc_pkg::ORG_X16);
      width = x16 ? dmc_pkg::DQ_X16 : (i_org == dmc_pkg::ORG_X8) ? dmc_pkg::DQ_X8 : dmc_pkg::DQ_X4;
      o_term = '0;
      for (int k = 0; k < dmc_pkg::DQ_X16; k++) begin
         o_term[k] = i_on & (k < width);
      end
      o_term[dmc_pkg::TERM_DQS_LO] = i_on;
      o_term[dmc_pkg::TERM_DM_LO]  = i_on;
      o_term[dmc_pkg::TERM_DQS_UP] = i_on & x16;
      o_term[dmc_pkg::TERM_DM_UP]  = i_on & x16;
      o_term[dmc_pkg::TERM_TDQS_C] = i_on & ~x16 & i_tdqs_en;
   end
endmodule : dmc_term
`default_nettype wire

//--- src/dmc_ctrl.sv
// Purpose : Command/control pin handling of a registered nonvolatile module
// Assumes : All pins synchronous to I_REF_CLK; mode bits arrive as ports
// Notes   : Outputs are registered; device reset pin acts asynchronously
`timescale 1ns/1ps
`default_nettype none
module dmc_ctrl #(
   parameter int RANKS = dmc_pkg::RANKS_DEF
) (
   input  wire logic                         I_REF_CLK,
   input  wire logic                         I_RSTN,
   input  wire logic                         I_RESET_PIN_N,
   input  wire logic                         I_CKE,
   input  wire logic [RANKS-1:0]             I_CS_N,
   input  wire logic                         I_ACT_N,
   input  wire logic                         I_RAS_N,
   input  wire logic                         I_CAS_N,
   input  wire logic                         I_WE_N,
   input  wire logic [dmc_pkg::BG_W-1:0]     I_BG,
   input  wire logic [dmc_pkg::BA_W-1:0]     I_BA,
   input  wire logic [dmc_pkg::ADDR_W-1:0]   I_ADDR,
   input  wire logic                         I_PARITY,
   input  wire logic                         I_ODT,
   input  wire logic [dmc_pkg::SA_W-1:0]     I_SA,
   input  wire logic                         I_SAVE_N,
   input  wire logic                         I_BACKUP_ARMED,
   input  wire logic                         I_BANKS_OPEN,
   input  wire logic                         I_SREF_REQ,
   input  wire logic                         I_PAR_EN,
   input  wire logic                         I_RTT_EN,
   input  wire logic                         I_TDQS_EN,
   input  wire logic                         I_CRC_EN,
   input  wire logic                         I_VREF_MON,
   input  wire logic                         I_VREF_ALL,
   input  wire logic [dmc_pkg::ORG_W-1:0]    I_ORG,
   input  wire logic                         I_BURST_LAST,
   output logic                              O_CLK_ON,
   output logic [dmc_pkg::BUF_W-1:0]         O_BUF_EN,
   output logic [1:0]                        O_PWR_STATE,
   output logic [RANKS-1:0]                  O_CMD_VALID,
   output logic                              O_ROW_CMD,
   output logic [dmc_pkg::ADDR_W-1:0]        O_ROW_ADDR,
   output logic [2:0]                        O_CMD_BITS,
   output logic                              O_PAR_ERR,
   output logic [dmc_pkg::TERM_W-1:0]        O_TERM,
   output logic [6:0]                        O_SPD_ADDR,
   output logic [6:0]                        O_TSEN_ADDR,
   output logic [4:0]                        O_DQ_WIDTH,
   output logic                              O_CRC_BEAT,
   output logic [dmc_pkg::VREF_LANES-1:0]    O_VREF_OUT,
   output logic                              O_TRAIN_LONG,
   output logic                              O_SAVE_REQ,
   output logic                              O_DEV_RST_N
);
   // ----------------------------------------------------------------
   // Elaboration check
   // ----------------------------------------------------------------
   if (RANKS < 1 || RANKS > 4) begin : g_bad_ranks
      $error("RANKS must be 1 to 4");
   end

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   typedef struct packed {
      dmc_pkg::dmc_pwr_type             pwr;
      logic                             clk_on;
      logic [dmc_pkg::BUF_W-1:0]        buf_en;
      logic [RANKS-1:0]                 cmd_valid;
      logic                             row_cmd;
      logic [dmc_pkg::ADDR_W-1:0]       row_addr;
      logic [2:0]                       cmd_bits;
      logic                             par_err;
      logic                             odt_on;
      logic [6:0]                       spd_addr;
      logic [6:0]                       tsen_addr;
      logic [4:0]                       dq_width;
      logic                             crc_beat;
      logic [dmc_pkg::VREF_LANES-1:0]   vref_out;
      logic                             train_long;
      logic                             save_req;
   } dmc_state_type;

   dmc_state_type st_q;
   dmc_state_type st_d;

   logic                        par_err_w;
   logic                        any_sel;
   logic [dmc_pkg::TERM_W-1:0]  term_w;
   logic [dmc_pkg::TERM_W-1:0]  term_q;
   logic                        dev_rst_n_q;
   logic                        rst_blk;

   // ----------------------------------------------------------------
   // Parity checker
   // ----------------------------------------------------------------
   assign any_sel = ~&I_CS_N;
   dmc_parity u_par (
      .i_en    (I_PAR_EN),
      .i_sel   (any_sel),
      .i_act_n (I_ACT_N),
      .i_ras_n (I_RAS_N),
      .i_cas_n (I_CAS_N),
      .i_we_n  (I_WE_N),
      .i_bg    (I_BG),
      .i_ba    (I_BA),
      .i_addr  (I_ADDR),
      .i_par   (I_PARITY),
      .o_err   (par_err_w)
   );

   // ----------------------------------------------------------------
   // Termination map
   // ----------------------------------------------------------------
   dmc_term u_term (
      .i_on      (st_q.odt_on),
      .i_org     (I_ORG),
      .i_tdqs_en (I_TDQS_EN),
      .o_term    (term_w)
   );

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   always_comb begin
      st_d = st_q;
      // Power state machine
      case (st_q.pwr)
         dmc_pkg::PWR_ACTIVE: begin
            if (!I_CKE) begin
               if (I_BANKS_OPEN) begin
                  st_d.pwr = dmc_pkg::PWR_APD;
               end else if (I_SREF_REQ) begin
                  st_d.pwr = dmc_pkg::PWR_SREF;
               end else begin
                  st_d.pwr = dmc_pkg::PWR_PPD;
               end
            end
         end
         dmc_pkg::PWR_APD, dmc_pkg::PWR_PPD: begin
            if (I_CKE) begin
               st_d.pwr = dmc_pkg::PWR_ACTIVE;
            end
         end
         dmc_pkg::PWR_SREF: begin
            if (I_CKE) begin
               st_d.pwr = dmc_pkg::PWR_ACTIVE;
            end
         end
         default: begin
            st_d.pwr = dmc_pkg::PWR_ACTIVE;
         end
      endcase
      // Clock tree follows CKE; input buffers follow the next power state, CKE and reset buffers stay on
      st_d.clk_on = I_CKE;
      st_d.buf_en = '0;
      st_d.buf_en[dmc_pkg::BUF_CKE] = 1'b1;
      st_d.buf_en[dmc_pkg::BUF_RST] = 1'b1;
      if (st_d.pwr != dmc_pkg::PWR_SREF) begin
         st_d.buf_en[dmc_pkg::BUF_CK]  = 1'b1;
         st_d.buf_en[dmc_pkg::BUF_ODT] = 1'b1;
      end
      if (st_d.pwr == dmc_pkg::PWR_ACTIVE) begin
         st_d.buf_en[dmc_pkg::BUF_CMD] = 1'b1;
      end
      // Command acceptance per rank, sampled this edge
      for (int r = 0; r < RANKS; r++) begin
         st_d.cmd_valid[r] = ~I_CS_N[r] & (st_q.pwr == dmc_pkg::PWR_ACTIVE) & I_CKE;
      end
      // Dual use of RAS/CAS/WE
      st_d.row_cmd  = any_sel & ~I_ACT_N;
      st_d.row_addr = I_ADDR;
      st_d.cmd_bits = 3'h0;
      if (!I_ACT_N) begin
         st_d.row_addr[dmc_pkg::ROW_RAS_BIT] = I_RAS_N;
         st_d.row_addr[dmc_pkg::ROW_CAS_BIT] = I_CAS_N;
         st_d.row_addr[dmc_pkg::ROW_WE_BIT]  = I_WE_N;
      end else begin
         st_d.cmd_bits = {I_RAS_N, I_CAS_N, I_WE_N};
      end
      // Parity error sticks until parity is disabled
      st_d.par_err = I_PAR_EN & (st_q.par_err | par_err_w);
      // Termination request, ignored when termination is off
      st_d.odt_on = I_RTT_EN & I_ODT & (st_q.pwr != dmc_pkg::PWR_SREF);
      // Bus address straps
      st_d.spd_addr  = {dmc_pkg::SPD_BASE[6:3], I_SA};
      st_d.tsen_addr = {dmc_pkg::TSEN_BASE[6:3], I_SA};
      // Data width per organisation
      case (I_ORG)
         dmc_pkg::ORG_X8:  st_d.dq_width = 5'(dmc_pkg::DQ_X8);
         dmc_pkg::ORG_X16: st_d.dq_width = 5'(dmc_pkg::DQ_X16);
         default:          st_d.dq_width = 5'(dmc_pkg::DQ_X4);
      endcase
      // CRC beat follows the last data beat
      st_d.crc_beat = I_CRC_EN & I_BURST_LAST;
      // Reference level monitor
      st_d.vref_out   = '0;
      st_d.train_long = I_VREF_MON;
      if (I_VREF_MON) begin
         st_d.vref_out = I_VREF_ALL ? '1 : 4'h1;
      end
      // Force save only honoured in self refresh
      st_d.save_req = ~I_SAVE_N & (st_q.pwr == dmc_pkg::PWR_SREF);
   end

   // ----------------------------------------------------------------
   // State register
   // ----------------------------------------------------------------
   always_ff @(posedge I_REF_CLK) begin
      if (!I_RSTN) begin
         st_q        <= '0;
         st_q.pwr    <= dmc_pkg::PWR_ACTIVE;
         st_q.buf_en <= '1;
         term_q      <= '0;
      end else begin
         st_q   <= st_d;
         term_q <= term_w;
      end
   end

   // ----------------------------------------------------------------
   // Device reset pin, asynchronous, blocked while armed
   // ----------------------------------------------------------------
   assign rst_blk = ~I_RESET_PIN_N & ~I_BACKUP_ARMED;
   always_ff @(posedge I_REF_CLK or posedge rst_blk) begin
      if (rst_blk) begin
         dev_rst_n_q <= 1'b0;
      end else if (!I_RSTN) begin
         dev_rst_n_q <= 1'b0;
      end else begin
         dev_rst_n_q <= 1'b1;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   assign O_CLK_ON     = st_q.clk_on;
   assign O_BUF_EN     = st_q.buf_en;
   assign O_PWR_STATE  = st_q.pwr;
   assign O_CMD_VALID  = st_q.cmd_valid;
   assign O_ROW_CMD    = st_q.row_cmd;
   assign O_ROW_ADDR   = st_q.row_addr;
   assign O_CMD_BITS   = st_q.cmd_bits;
   assign O_PAR_ERR    = st_q.par_err;
   assign O_TERM       = term_q;
   assign O_SPD_ADDR   = st_q.spd_addr;
   assign O_TSEN_ADDR  = st_q.tsen_addr;
   assign O_DQ_WIDTH   = st_q.dq_width;
   assign O_CRC_BEAT   = st_q.crc_beat;
   assign O_VREF_OUT   = st_q.vref_out;
   assign O_TRAIN_LONG = st_q.train_long;
   assign O_SAVE_REQ   = st_q.save_req;
   assign O_DEV_RST_N  = dev_rst_n_q;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   // Clock enable, power states and input buffers
   cke_clock_a: assert property (@(posedge I_REF_CLK) disable iff (!I_RSTN)
      1'b1 |=> O_CLK_ON == $past(I_CKE)) else $error("clock enable not followed");
   active_bufs_a: assert property (@(posedge I_REF_CLK) disable iff (!I_RSTN)
      (O_PWR_STATE == dmc_pkg::PWR_ACTIVE) |-> O_BUF_EN == 5'h1f) else $error("active buffers wrong");
   cke_mask_a: assert property (@(posedge I_REF_CLK) disable iff (!I_RSTN)
      (!I_CKE) |=> O_CMD_VALID == '0) else $error("command accepted with clock enable low");
   apd_entry_a: assert property (@(posedge I_REF_CLK) disable iff (!I_RSTN)
      (O_PWR_STATE == dmc_pkg::PWR_ACTIVE && !I_CKE && I_BANKS_OPEN)
      |=> O_PWR_STATE == dmc_pkg::PWR_APD) else $error("active power-down not entered");
   ppd_entry_a: assert property (@(posedge I_REF_CLK) disable iff (!I_RSTN)
      (O_PWR_STATE == dmc_pkg::PWR_ACTIVE && !I_CKE && !I_BANKS_OPEN && !I_SREF_REQ)
      |=> O_PWR_STATE == dmc_pkg::PWR_PPD) else $error("precharge power-down not entered");
   sref_entry_a: assert property (@(posedge I_REF_CLK) disable iff (!I_RSTN)
      (O_PWR_STATE == dmc_pkg::PWR_ACTIVE && !I_CKE && !I_BANKS_OPEN && I_SREF_REQ)
      |=> O_PWR_STATE == dmc_pkg::PWR_SREF) else $error("self refresh not entered");
   sref_exit_a: assert property (@(posedge I_REF_CLK) disable iff (!I_RSTN)
      (O_PWR_STATE == dmc_pkg::PWR_SREF && I_CKE)
      |=> O_PWR_STATE == dmc_pkg::PWR_ACTIVE) else $error("self refresh exit late");
   pd_buffers_a: assert property (@(posedge I_REF_CLK) disable iff (!I_RSTN)
      (O_PWR_STATE == dmc_pkg::PWR_PPD || O_PWR_STATE == dmc_pkg::PWR_APD) |-> O_BUF_EN == 5'h0f)
      else $error("power-down buffers wrong");
   sref_buffers_a: assert property (@(posedge I_REF_CLK) disable iff (!I_RSTN)
      (O_PWR_STATE == dmc_pkg::PWR_SREF) |-> O_BUF_EN == 5'h0c) else $error("self refresh buffers wrong");
   odt_sref_a: assert property (@(posedge I_REF_CLK) disable iff (!I_RSTN)
      (O_PWR_STATE == dmc_pkg::PWR_SREF) |=> ##1 O_TERM == '0)
      else $error("termination applied in self refresh");

   // Command acceptance, parity and pin reuse
   cs_mask_a: assert property (@(posedge I_REF_CLK) disable iff (!I_RSTN)
      (I_CS_N[0]) |=> !O_CMD_VALID[0]) else $error("deselected command accepted");
   rank_accept_a: assert property (@(posedge I_REF_CLK) disable iff (!I_RSTN)
      (O_PWR_STATE == dmc_pkg::PWR_ACTIVE && I_CKE && !I_CS_N[0]) |=> O_CMD_VALID[0])
      else $error("selected rank refused command");
   par_catch_a: assert property (@(posedge I_REF_CLK) disable iff (!I_RSTN)
      (I_PAR_EN && !(&I_CS_N) && I_PARITY != ^{I_ACT_N, I_RAS_N, I_CAS_N, I_WE_N, I_BG, I_BA, I_ADDR})
      |=> O_PAR_ERR) else $error("parity error missed");
   par_sticky_a: assert property (@(posedge I_REF_CLK) disable iff (!I_RSTN)
      (I_PAR_EN && O_PAR_ERR) |=> O_PAR_ERR) else $error("parity error not held");
   par_off_a: assert property (@(posedge I_REF_CLK) disable iff (!I_RSTN)
      (!I_PAR_EN) |=> !O_PAR_ERR) else $error("parity error while disabled");
   row_bits_a: assert property (@(posedge I_REF_CLK) disable iff (!I_RSTN)
      (!I_ACT_N) |=> O_ROW_ADDR[dmc_pkg::ROW_RAS_BIT] == $past(I_RAS_N) && O_CMD_BITS == 3'h0)
      else $error("row bit mapping wrong");
   col_bits_a: assert property (@(posedge I_REF_CLK) disable iff (!I_RSTN)
      (I_ACT_N) |=> !O_ROW_CMD && O_CMD_BITS[2] == $past(I_RAS_N) && O_CMD_BITS[0] == $past(I_WE_N))
      else $error("command bit mapping wrong");

   // Termination, reset and option pins
   odt_term_a: assert property (@(posedge I_REF_CLK) disable iff (!I_RSTN)
      (I_RTT_EN && I_ODT && O_PWR_STATE != dmc_pkg::PWR_SREF)
      |=> ##1 O_TERM[0] && O_TERM[dmc_pkg::TERM_DQS_LO]) else $error("termination not applied");
   rtt_off_a: assert property (@(posedge I_REF_CLK) disable iff (!I_RSTN)
      (!I_RTT_EN) |=> ##1 O_TERM == '0) else $error("ODT honoured while disabled");
   pin_reset_a: assert property (@(posedge I_REF_CLK) disable iff (!I_RSTN)
      (!I_RESET_PIN_N && !I_BACKUP_ARMED) |-> !O_DEV_RST_N) else $error("reset pin not honoured");
   rst_block_a: assert property (@(posedge I_REF_CLK) disable iff (!I_RSTN)
      (I_BACKUP_ARMED && $past(I_BACKUP_ARMED) && $past(I_RSTN)) |-> O_DEV_RST_N)
      else $error("reset acted while armed");
   strap_addr_a: assert property (@(posedge I_REF_CLK) disable iff (!I_RSTN)
      1'b1 |=> O_SPD_ADDR[dmc_pkg::SA_W-1:0] == $past(I_SA) && O_TSEN_ADDR[dmc_pkg::SA_W-1:0] == $past(I_SA))
      else $error("strap address wrong");
   x16_width_a: assert property (@(posedge I_REF_CLK) disable iff (!I_RSTN)
      (I_ORG == dmc_pkg::ORG_X16) |=> O_DQ_WIDTH == 5'(dmc_pkg::DQ_X16)) else $error("data width wrong");
   crc_beat_a: assert property (@(posedge I_REF_CLK) disable iff (!I_RSTN)
      (I_CRC_EN && I_BURST_LAST) |=> O_CRC_BEAT) else $error("check beat missing");
   vref_lane_a: assert property (@(posedge I_REF_CLK) disable iff (!I_RSTN)
      (I_VREF_MON) |=> O_VREF_OUT[0] && O_TRAIN_LONG) else $error("reference monitor lane off");
   save_gate_a: assert property (@(posedge I_REF_CLK) disable iff (!I_RSTN)
      (O_PWR_STATE != dmc_pkg::PWR_SREF) |=> !O_SAVE_REQ) else $error("save honoured outside self refresh");
endmodule : dmc_ctrl
`default_nettype wire

//--- bench/dmc_host.sv
// Purpose : Host memory controller model for the command/control pins
// Assumes : Pins change by non-blocking assignment at the rising edge
// Notes   : Deselected command and address lines show the inverse of their last value; bank group and bank lines hold
`timescale 1ns/1ps
`default_nettype none
module dmc_host #(
   parameter int RANKS = 2
) (
   input  wire logic                         i_clk,
   output logic [RANKS-1:0]                  o_cs_n,
   output logic                              o_act_n,
   output logic [2:0]                        o_rcw_n,
   output logic [dmc_pkg::BG_W-1:0]          o_bg,
   output logic [dmc_pkg::BA_W-1:0]          o_ba,
   output logic [dmc_pkg::ADDR_W-1:0]        o_addr,
   output logic                              o_par,
   output logic                              o_cke
);
   // ----------------------------------------------------------------
   // Idle levels and access tasks
   // ----------------------------------------------------------------
   // Idle: no rank selected, clock enable high
   initial begin
      o_cs_n  = '1;
      o_act_n = 1'b1;
      o_rcw_n = 3'b111;
      o_bg    = 2'h2;
      o_ba    = 2'h1;
      o_addr  = '0;
      o_par   = 1'b0;
      o_cke   = 1'b1;
   end

   // One command with even parity in its own cycle; bad flips the parity bit
   task automatic cmd(input logic [RANKS-1:0] sel, input logic act, input logic [2:0] rcw,
                      input logic [dmc_pkg::ADDR_W-1:0] a, input logic bad);
      @(posedge i_clk);
      o_cke   <= 1'b1;
      o_cs_n  <= ~sel;
      o_act_n <= act;
      o_rcw_n <= rcw;
      o_addr  <= a;
      o_par   <= ^{act, rcw, o_bg, o_ba, a} ^ bad;
      @(posedge i_clk);
      o_cs_n  <= '1;
      o_act_n <= ~act;
      o_rcw_n <= ~rcw;
      o_addr  <= ~a;
      o_par   <= ~o_par;
   endtask : cmd

   // Clock-enable change, returns at the edge that samples it
   task automatic cke(input logic v);
      @(posedge i_clk);
      o_cke <= v;
      @(posedge i_clk);
   endtask : cke
endmodule : dmc_host
`default_nettype wire

//--- bench/tb_ddr4_module_command_control_pins.sv
// Purpose : Self-checking bench for the module command/control pin logic
// Assumes : Host model drives commands; bench drives mode and board pins
// Notes   : Checks land one nanosecond after the sampling edge
`timescale 1ns/1ps
`default_nettype none
module tb_ddr4_module_command_control_pins;
   logic        clk, rstn, rpin_n, save_n, armed, banks, sref, par_en;
   logic        rtt, tdqs, crc, vmon, vall, odt, last;
   logic [1:0]  org, cs_n, bg, ba, pwr, vld;
   logic [2:0]  sa, rcw, cbits;
   logic [16:0] addr, row_addr;
   logic [4:0]  buf_en, dqw;
   logic [21:0] term;
   logic [6:0]  spd, tsen;
   logic [3:0]  vref;
   logic        act_n, par, cke, clk_on, row_cmd, par_err, crc_beat, train, save_req, dev_rst_n;
   int          errors = 0;
   int          n_checks = 0;
   logic [1:0]  pst [3] = '{2'b11, 2'b01, 2'b10};
   logic [5:0]  bex [3] = '{6'h0f, 6'h0f, 6'h0c};
   logic [4:0]  tcfg [6] = '{5'h03, 5'h0b, 5'h0f, 5'h13, 5'h11, 5'h0a};
   logic [21:0] texp [6] = '{22'h05000f, 22'h0500ff, 22'h1500ff, 22'h0fffff, 22'h0, 22'h0};
   logic [4:0]  wexp [6] = '{5'h04, 5'h08, 5'h08, 5'h10, 5'h10, 5'h08};

   // ----------------------------------------------------------------
   // Clock, host model and design
   // ----------------------------------------------------------------
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   dmc_host #(.RANKS(2)) i_host (.i_clk(clk), .o_cs_n(cs_n), .o_act_n(act_n), .o_rcw_n(rcw), .o_bg(bg),
      .o_ba(ba), .o_addr(addr), .o_par(par), .o_cke(cke));

   dmc_ctrl #(.RANKS(2)) i_dut (.I_REF_CLK(clk), .I_RSTN(rstn), .I_RESET_PIN_N(rpin_n), .I_CKE(cke),
      .I_CS_N(cs_n), .I_ACT_N(act_n), .I_RAS_N(rcw[2]), .I_CAS_N(rcw[1]), .I_WE_N(rcw[0]), .I_BG(bg),
      .I_BA(ba), .I_ADDR(addr), .I_PARITY(par), .I_ODT(odt), .I_SA(sa), .I_SAVE_N(save_n),
      .I_BACKUP_ARMED(armed), .I_BANKS_OPEN(banks), .I_SREF_REQ(sref), .I_PAR_EN(par_en), .I_RTT_EN(rtt),
      .I_TDQS_EN(tdqs), .I_CRC_EN(crc), .I_VREF_MON(vmon), .I_VREF_ALL(vall), .I_ORG(org),
      .I_BURST_LAST(last), .O_CLK_ON(clk_on), .O_BUF_EN(buf_en), .O_PWR_STATE(pwr), .O_CMD_VALID(vld),
      .O_ROW_CMD(row_cmd), .O_ROW_ADDR(row_addr), .O_CMD_BITS(cbits), .O_PAR_ERR(par_err),
      .O_TERM(term), .O_SPD_ADDR(spd), .O_TSEN_ADDR(tsen), .O_DQ_WIDTH(dqw), .O_CRC_BEAT(crc_beat),
      .O_VREF_OUT(vref), .O_TRAIN_LONG(train), .O_SAVE_REQ(save_req), .O_DEV_RST_N(dev_rst_n));

   // ----------------------------------------------------------------
   // Compare, step and close tasks
   // ----------------------------------------------------------------
   task automatic chk(input string nm, input logic [21:0] seen, input logic [21:0] exp);
      n_checks++;
      if (seen !== exp) begin
         errors++;
         $display("mismatch %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk

   task automatic nx(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : nx

   task automatic close_out;
      $display("checks %0d errors %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : close_out

   // Watchdog against a hung sequence
   initial begin
      repeat (5000) @(posedge clk);
      errors++;
      close_out;
   end

   // ----------------------------------------------------------------
   // Test sequence
   // ----------------------------------------------------------------
   initial begin
      {rstn, rpin_n, save_n, armed, banks, sref, par_en, rtt, tdqs, crc, vmon, vall, odt, last} = 14'h1800;
      org = 2'h0;
      sa  = 3'h5;
      repeat (12) @(posedge clk);
      #1;
      chk("buf_rst", buf_en, 22'h1f);
      chk("dev_rst", dev_rst_n, 22'h0);
      @(posedge clk) rstn <= 1'b1;
      nx(2);
      chk("dev_rst", dev_rst_n, 22'h1);
      chk("spd", spd, dmc_pkg::SPD_BASE | 7'h5);
      chk("tsen", tsen, dmc_pkg::TSEN_BASE | 7'h5);
      // Row command rank 0, column command rank 1, then nothing selected
      i_host.cmd(2'b01, 1'b0, 3'b101, 17'h01234, 1'b0);
      #1;
      chk("vld", vld, 2'b01);
      chk("row", {row_cmd, row_addr}, {1'b1, 3'b101, 14'h1234});
      i_host.cmd(2'b10, 1'b1, 3'b011, 17'h00abc, 1'b0);
      #1;
      chk("vld", vld, 2'b10);
      chk("cbits", {row_cmd, cbits}, 4'h3);
      i_host.cmd(2'b00, 1'b0, 3'b111, 17'h1ffff, 1'b0);
      #1;
      chk("vld", vld, 2'b00);
      // Parity good, bad, sticky, cleared by disabling
      @(posedge clk) par_en <= 1'b1;
      i_host.cmd(2'b01, 1'b0, 3'b010, 17'h00f0f, 1'b0);
      #1;
      chk("par", par_err, 1'b0);
      i_host.cmd(2'b01, 1'b1, 3'b110, 17'h10001, 1'b1);
      #1;
      chk("par", par_err, 1'b1);
      i_host.cmd(2'b10, 1'b0, 3'b001, 17'h00555, 1'b0);
      #1;
      chk("par", par_err, 1'b1);
      @(posedge clk) par_en <= 1'b0;
      nx(1);
      chk("par", par_err, 1'b0);
      // Clock enable low per bank and refresh condition, save in self refresh, wake
      for (int i = 0; i < 3; i++) begin
         @(posedge clk);
         banks <= (i == 1);
         sref  <= (i == 2);
         i_host.cke(1'b0);
         #1;
         chk("pwr", pwr, pst[i]);
         chk("buf", {clk_on, buf_en}, bex[i]);
         if (i == 2) begin
            @(posedge clk) save_n <= 1'b0;
            nx(1);
            chk("save", save_req, 1'b1);
            @(posedge clk) save_n <= 1'b1;
         end
         i_host.cke(1'b1);
         #1;
         chk("wake", {pwr, clk_on, buf_en}, 8'h3f);
      end
      // Termination map and data width per organisation and mode bits
      for (int i = 0; i < 6; i++) begin
         @(posedge clk) {org, tdqs, rtt, odt} <= tcfg[i];
         nx(2);
         chk("term", term, texp[i]);
         chk("width", dqw, wexp[i]);
      end
      // Check beat after last data beat, reference monitor lanes
      @(posedge clk);
      crc  <= 1'b1;
      last <= 1'b1;
      vmon <= 1'b1;
      @(posedge clk) last <= 1'b0;
      #1;
      chk("crc", crc_beat, 1'b1);
      chk("vref", {train, vref}, 5'h11);
      @(posedge clk) vall <= 1'b1;
      nx(1);
      chk("crc", crc_beat, 1'b0);
      chk("vref", {train, vref}, 5'h1f);
      // Reset pin acts at once, then is blocked while armed
      @(posedge clk) rpin_n <= 1'b0;
      #1;
      chk("rst_pin", dev_rst_n, 1'b0);
      @(posedge clk);
      rpin_n <= 1'b1;
      armed  <= 1'b1;
      nx(2);
      chk("rst_pin", dev_rst_n, 1'b1);
      @(posedge clk) rpin_n <= 1'b0;
      nx(2);
      chk("armed", dev_rst_n, 1'b1);
      close_out;
   end
endmodule : tb_ddr4_module_command_control_pins
`default_nettype wire
